/* File: logic/acp_params.svh */
// constants for the converter power and sequencing control
`ifndef ACP_PARAMS_SVH
`define ACP_PARAMS_SVH

// control word layout
`define ACP_CTRL_W        8
`define ACP_CTRL_RESET    8'h00
`define ACP_PM_LOW_BIT    0
`define ACP_PM_HIGH_BIT   1
`define ACP_TWO_CH_BIT    2
`define ACP_CHAN_BIT      3
`define ACP_REF_OFF_BIT   5

// frame sequencing, counted in serial clock edges after select falls
`define ACP_CTRL_RISES    5'h08
`define ACP_SAMPLE_RISE   5'h02
`define ACP_FRAME_RISES   5'h10
`define ACP_FALL_MAX      4'hf
`define ACP_RESULT_W      12
`define ACP_WORD_W        16
`define ACP_LEAD_ZEROS    4'h0

// wake-up times
`define ACP_CLK_NS        100
`define ACP_WAKE_FULL_NS  5000
`define ACP_WAKE_SHORT_NS 1000
`define ACP_WAKE_FULL_CYC  ((`ACP_WAKE_FULL_NS + `ACP_CLK_NS - 1) / `ACP_CLK_NS)
`define ACP_WAKE_SHORT_CYC ((`ACP_WAKE_SHORT_NS + `ACP_CLK_NS - 1) / `ACP_CLK_NS)
`define ACP_WAKE_CNT_W    7

// result buffer
`define ACP_FIFO_DEPTH    32

`endif

/* File: logic/acp_pkg.sv */
// types shared by the converter power control
package acp_pkg;

  typedef enum logic [1:0] {
    ACP_SELECT_GATED_POWER_MODE = 2'b00,
    ACP_ALWAYS_ON_MODE          = 2'b01,
    ACP_AUTO_SHUTDOWN_MODE      = 2'b10,
    ACP_AUTO_STANDBY_MODE       = 2'b11
  } acp_mode_t;

  typedef enum logic [1:0] {
    ACP_PWR_OFF     = 2'b00,
    ACP_PWR_STANDBY = 2'b01,
    ACP_PWR_WAKING  = 2'b10,
    ACP_PWR_ON      = 2'b11
  } acp_pwr_t;

endpackage : acp_pkg

/* File: logic/acp_pin_sync.sv */
// two-stage synchroniser for a group of asynchronous pins
`timescale 1ns/1ns
`default_nettype none

module acp_pin_sync #(
  parameter int N = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // pins in, synchronised copy out
  input  wire logic [N-1:0] pin_i,
  output logic      [N-1:0] pin_s
);

  for (genvar i = 0; i < N; i++) begin : g_bit
    logic meta_q;
    logic hold_q;
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        meta_q <= 1'b1;
        hold_q <= 1'b1;
      end else begin
        meta_q <= pin_i[i];
        hold_q <= meta_q;
      end
    end
    assign pin_s[i] = hold_q;
  end

endmodule : acp_pin_sync

`default_nettype wire

/* File: logic/acp_fifo.sv */
// result buffer: width and depth are parameters, valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none

module acp_fifo #(
  parameter int W     = 12,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // fill side
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  // drain side
  output logic      [W-1:0] out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d;
  logic [AW-1:0] rd_q, rd_d;
  logic [AW:0]   cnt_q, cnt_d;
  logic          push;
  logic          pop;

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    wr_d  = push ? ((wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1) : wr_q;
    rd_d  = pop ? ((rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1) : rd_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // storage holds no reset: contents only matter once counted in
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

endmodule : acp_fifo

`default_nettype wire

/* File: logic/acp_adc_power_ctrl.sv */
// power-mode and conversion sequencing control of a two-channel serial converter
`include "acp_params.svh"
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - Internal reference on when reference-off bit is 0, off when 1; on by default.
// - Two-channel configuration uses the supply as reference, ignoring reference-off.
// - Two power-select bits of the control word choose one of four modes.
// - Auto modes power down on the 16th rising serial clock after select falls.
// - Auto modes start waking on the first falling serial clock after select falls.
// - Select-gated mode, the default: down on select rising, up on select falling.
// - Select-gated mode: select rising mid-conversion powers down at once, conversion abandoned.
// - After power-on the device starts in select-gated mode, power bits 00.
// - Wake from standby, or single-channel with reference off, takes about 1 us.
// - Auto-standby keeps the internal reference up while other circuits sleep.
// - Power bits 10 select auto-shutdown: power down after every conversion.
// - Serial input held low loads an all-zero control word every transfer.
// - Select-gated mode samples on the second rising serial clock after select falls.
// - Power bits 01 keep the device fully powered whatever select does.
// - First eight serial input bits of each transfer load the control word.
// - Each conversion and result transfer takes sixteen serial clocks from select falling.
// - Always-on mode accepts a new conversion on the next select low after high.
// - Power bits 11 select auto-standby: standby after every conversion.
// - Track for 1.5 serial clocks after select falls, then convert 14.5 more.
// - Result shifts out as four zeros then 12 bits, most significant first.
// - Select rising after conversion returns serial data output to high impedance.
module acp_adc_power_ctrl #(
  parameter int RES_W      = `ACP_RESULT_W,
  parameter int FIFO_DEPTH = `ACP_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             arst_n,
  // serial link pins
  input  wire logic             cs_n,
  input  wire logic             sclk,
  input  wire logic             din,
  output logic                  dout_o,
  output logic                  dout_oe,
  // results from the converter core
  input  wire logic [RES_W-1:0] res_data,
  input  wire logic             res_valid,
  output logic                  res_ready,
  // configuration and power status
  output logic [`ACP_CTRL_W-1:0] ctrl_word,
  output logic [1:0]            pm_mode,
  output logic                  channel_sel,
  output logic                  ref_enable,
  output logic                  ref_is_supply,
  output logic                  pwr_on,
  output logic                  pwr_waking,
  // conversion status
  output logic                  track,
  output logic                  sample_pulse,
  output logic                  conv_busy,
  output logic                  conv_done,
  output logic                  conv_abort
);

  localparam logic [3:0] FIRST_SHIFT = 4'(`ACP_WORD_W - 2);
  localparam logic [`ACP_WAKE_CNT_W-1:0] WAKE_FULL  = `ACP_WAKE_CNT_W'(`ACP_WAKE_FULL_CYC - 1);
  localparam logic [`ACP_WAKE_CNT_W-1:0] WAKE_SHORT = `ACP_WAKE_CNT_W'(`ACP_WAKE_SHORT_CYC - 1);

  // reset release
  logic [1:0] rst_pipe_q;
  logic       rst_n;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_pipe_q <= 2'b00;
    end else begin
      rst_pipe_q <= {rst_pipe_q[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe_q[1];

  // pin synchronisers and edge finding
  logic [2:0] pins_s;
  logic       cs_s, sclk_s, din_s;
  logic       cs_prev_q, sclk_prev_q;
  logic       cs_fall, cs_rise, rise_evt, fall_evt;

  acp_pin_sync #(.N(3)) u_sync (
    .clk   (ref_clk),
    .rst_n (rst_n),
    .pin_i ({cs_n, sclk, din}),
    .pin_s (pins_s)
  );
  assign {cs_s, sclk_s, din_s} = pins_s;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_prev_q   <= 1'b1;
      sclk_prev_q <= 1'b1;
    end else begin
      cs_prev_q   <= cs_s;
      sclk_prev_q <= sclk_s;
    end
  end

  // serial clock edges only count while select is low
  assign cs_fall  = cs_prev_q && !cs_s;
  assign cs_rise  = !cs_prev_q && cs_s;
  assign rise_evt = !cs_s && !cs_prev_q && !sclk_prev_q && sclk_s;
  assign fall_evt = !cs_s && !cs_prev_q && sclk_prev_q && !sclk_s;

  // result buffer
  logic [RES_W-1:0] buf_data;
  logic             buf_valid;
  logic             buf_pop;

  acp_fifo #(.W(RES_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (ref_clk),
    .rst_n     (rst_n),
    .in_data   (res_data),
    .in_valid  (res_valid),
    .in_ready  (res_ready),
    .out_data  (buf_data),
    .out_valid (buf_valid),
    .out_ready (buf_pop)
  );

  // frame sequencing state
  logic [4:0]             rise_cnt_q, rise_cnt_d;
  logic [3:0]             fall_cnt_q, fall_cnt_d;
  logic [`ACP_CTRL_W-1:0] ctrl_sr_q, ctrl_sr_d;
  logic [`ACP_CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [`ACP_WORD_W-1:0] word_q, word_d;
  logic                   dout_q, dout_d;
  logic                   oe_q, oe_d;
  logic                   track_q, track_d;
  logic                   busy_q, busy_d;
  logic                   sample_q, sample_d;
  logic                   done_q, done_d;
  logic                   abort_q, abort_d;
  logic                   sample_now;
  logic                   last_rise;
  logic                   first_fall;
  acp_pkg::acp_mode_t     mode;

  assign mode       = acp_pkg::acp_mode_t'({ctrl_q[`ACP_PM_HIGH_BIT], ctrl_q[`ACP_PM_LOW_BIT]});
  assign sample_now = rise_evt && (rise_cnt_q == `ACP_SAMPLE_RISE - 5'h01);
  assign last_rise  = rise_evt && (rise_cnt_q == `ACP_FRAME_RISES - 5'h01);
  assign first_fall = fall_evt && (fall_cnt_q == 4'h0);
  assign buf_pop    = sample_now;

  always_comb begin
    rise_cnt_d = rise_cnt_q;
    fall_cnt_d = fall_cnt_q;
    ctrl_sr_d  = ctrl_sr_q;
    ctrl_d     = ctrl_q;
    word_d     = word_q;
    dout_d     = dout_q;
    oe_d       = oe_q;
    track_d    = track_q;
    busy_d     = busy_q;
    sample_d   = 1'b0;
    done_d     = 1'b0;
    abort_d    = 1'b0;
    if (cs_fall) begin
      // a fresh frame may start after any high select, whatever the mode
      rise_cnt_d = 5'h00;
      fall_cnt_d = 4'h0;
      track_d    = 1'b1;
      busy_d     = 1'b0;
      word_d     = '0;
      oe_d       = 1'b1;
      dout_d     = 1'b0;
    end else if (cs_rise) begin
      oe_d    = 1'b0;
      track_d = 1'b0;
      busy_d  = 1'b0;
      abort_d = busy_q && (mode == acp_pkg::ACP_SELECT_GATED_POWER_MODE);
    end else begin
      if (rise_evt && (rise_cnt_q < `ACP_FRAME_RISES)) begin
        rise_cnt_d = rise_cnt_q + 5'h01;
        if (rise_cnt_q < `ACP_CTRL_RISES) begin
          ctrl_sr_d = {ctrl_sr_q[`ACP_CTRL_W-2:0], din_s};
        end
        if (rise_cnt_q == `ACP_CTRL_RISES - 5'h01) begin
          // a low input line gives an all-zero word here
          ctrl_d = {ctrl_sr_q[`ACP_CTRL_W-2:0], din_s};
        end
      end
      if (sample_now) begin
        sample_d = 1'b1;
        track_d  = 1'b0;
        busy_d   = 1'b1;
        // empty buffer reads back as zero rather than stalling the frame
        word_d   = {`ACP_LEAD_ZEROS, buf_valid ? buf_data : {RES_W{1'b0}}};
      end
      if (last_rise) begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end
      if (fall_evt && (fall_cnt_q != `ACP_FALL_MAX)) begin
        fall_cnt_d = fall_cnt_q + 4'h1;
        dout_d     = word_q[FIRST_SHIFT - fall_cnt_q];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rise_cnt_q <= 5'h00;
      fall_cnt_q <= 4'h0;
      ctrl_sr_q  <= `ACP_CTRL_RESET;
      ctrl_q     <= `ACP_CTRL_RESET;
      word_q     <= '0;
      dout_q     <= 1'b0;
      oe_q       <= 1'b0;
      track_q    <= 1'b0;
      busy_q     <= 1'b0;
      sample_q   <= 1'b0;
      done_q     <= 1'b0;
      abort_q    <= 1'b0;
    end else begin
      rise_cnt_q <= rise_cnt_d;
      fall_cnt_q <= fall_cnt_d;
      ctrl_sr_q  <= ctrl_sr_d;
      ctrl_q     <= ctrl_d;
      word_q     <= word_d;
      dout_q     <= dout_d;
      oe_q       <= oe_d;
      track_q    <= track_d;
      busy_q     <= busy_d;
      sample_q   <= sample_d;
      done_q     <= done_d;
      abort_q    <= abort_d;
    end
  end

  // power state
  acp_pkg::acp_pwr_t            pwr_q, pwr_d;
  logic [`ACP_WAKE_CNT_W-1:0]   wake_q, wake_d;
  logic                         asleep;
  logic                         wake_short;
  logic                         two_ch;
  logic                         ref_off;

  assign two_ch     = ctrl_q[`ACP_TWO_CH_BIT];
  assign ref_off    = ctrl_q[`ACP_REF_OFF_BIT];
  assign asleep     = (pwr_q == acp_pkg::ACP_PWR_OFF) || (pwr_q == acp_pkg::ACP_PWR_STANDBY);
  assign wake_short = (pwr_q == acp_pkg::ACP_PWR_STANDBY) || (!two_ch && ref_off);

  always_comb begin
    pwr_d  = pwr_q;
    wake_d = wake_q;
    if (pwr_q == acp_pkg::ACP_PWR_WAKING) begin
      if (wake_q == '0) begin
        pwr_d = acp_pkg::ACP_PWR_ON;
      end else begin
        wake_d = wake_q - 1'b1;
      end
    end
    case (mode)
      acp_pkg::ACP_SELECT_GATED_POWER_MODE: begin
        if (cs_rise) begin
          pwr_d = acp_pkg::ACP_PWR_OFF;
        end else if (cs_fall && asleep) begin
          pwr_d  = acp_pkg::ACP_PWR_WAKING;
          wake_d = wake_short ? WAKE_SHORT : WAKE_FULL;
        end
      end
      acp_pkg::ACP_ALWAYS_ON_MODE: begin
        if (asleep) begin
          pwr_d  = acp_pkg::ACP_PWR_WAKING;
          wake_d = wake_short ? WAKE_SHORT : WAKE_FULL;
        end
      end
      acp_pkg::ACP_AUTO_SHUTDOWN_MODE, acp_pkg::ACP_AUTO_STANDBY_MODE: begin
        if (last_rise) begin
          pwr_d = (mode == acp_pkg::ACP_AUTO_STANDBY_MODE) ?
                  acp_pkg::ACP_PWR_STANDBY : acp_pkg::ACP_PWR_OFF;
        end else if (first_fall && asleep) begin
          pwr_d  = acp_pkg::ACP_PWR_WAKING;
          wake_d = wake_short ? WAKE_SHORT : WAKE_FULL;
        end
      end
      default: begin
        pwr_d = pwr_q;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_q  <= acp_pkg::ACP_PWR_OFF;
      wake_q <= '0;
    end else begin
      pwr_q  <= pwr_d;
      wake_q <= wake_d;
    end
  end

  // outputs
  assign dout_o        = dout_q;
  assign dout_oe       = oe_q;
  assign ctrl_word     = ctrl_q;
  assign pm_mode       = mode;
  assign channel_sel   = ctrl_q[`ACP_CHAN_BIT];
  // reference stays up in standby, drops only in full shutdown
  assign ref_enable    = !ref_off && !two_ch && (pwr_q != acp_pkg::ACP_PWR_OFF);
  assign ref_is_supply = two_ch;
  assign pwr_on        = (pwr_q == acp_pkg::ACP_PWR_ON);
  assign pwr_waking    = (pwr_q == acp_pkg::ACP_PWR_WAKING);
  assign track         = track_q;
  assign sample_pulse  = sample_q;
  assign conv_busy     = busy_q;
  assign conv_done     = done_q;
  assign conv_abort    = abort_q;

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  chk_ctrl_load: assert property (
    (rise_evt && rise_cnt_q == 5'h07 && !cs_fall && !cs_rise) |=> (ctrl_q[0] == $past(din_s)))
    else $error("control word did not take the eighth input bit");

  chk_gated_down: assert property (
    (cs_rise && mode == acp_pkg::ACP_SELECT_GATED_POWER_MODE) |=> (pwr_q == acp_pkg::ACP_PWR_OFF))
    else $error("gated mode did not power down on select rising");

  chk_gated_abort: assert property (
    (cs_rise && busy_q && mode == acp_pkg::ACP_SELECT_GATED_POWER_MODE) |=> (conv_abort && !conv_busy))
    else $error("conversion not abandoned on select rising");

  chk_auto_down: assert property (
    (last_rise && mode == acp_pkg::ACP_AUTO_STANDBY_MODE) |=> (pwr_q == acp_pkg::ACP_PWR_STANDBY && ref_enable == (!ref_off && !two_ch)))
    else $error("auto standby did not enter standby on last rising edge");

  chk_auto_wake: assert property (
    (first_fall && asleep && mode[1] && !last_rise) |=> pwr_waking)
    else $error("auto mode did not start waking on first falling edge");

  chk_always_on: assert property (
    (mode == acp_pkg::ACP_ALWAYS_ON_MODE && $past(mode) == acp_pkg::ACP_ALWAYS_ON_MODE) |-> !asleep)
    else $error("always-on mode left the device asleep");

  chk_two_ch_ref: assert property (
    two_ch |-> (ref_is_supply && !ref_enable))
    else $error("two-channel setup did not use the supply as reference");

  chk_sample_edge: assert property (
    (sample_now && !cs_rise) |=> (sample_pulse && conv_busy && !track) ##1 !sample_pulse)
    else $error("sample not taken on second rising edge");

  chk_done_edge: assert property (
    (last_rise && busy_q) |=> (conv_done && !conv_busy))
    else $error("conversion did not end on sixteenth rising edge");

  chk_dout_hiz: assert property (
    cs_rise |=> !dout_oe)
    else $error("data output still driven after select rose");

endmodule : acp_adc_power_ctrl

`default_nettype wire

/* File: verification/acp_host_model.sv */
// host side of the serial link: select, serial clock and control bits
`timescale 1ns/1ns
`default_nettype none

module acp_host_model (
  // clock
  input  wire logic ref_clk,
  // link pins
  output logic      cs_n,
  output logic      sclk,
  output logic      din,
  input  wire logic dout
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din  = 1'b0;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : wait_cyc

  // serial clock stands still while select changes
  task automatic sel(input logic v);
    @(negedge ref_clk);
    cs_n = v;
    wait_cyc(5);
  endtask : sel

  // din settles a cycle ahead of the rise so it is through the synchroniser a cycle before the rise
  task automatic pulse(input logic d, output logic q);
    din = d;
    wait_cyc(1);
    q    = dout;
    sclk = 1'b1;
    wait_cyc(4);
    sclk = 1'b0;
    wait_cyc(3);
  endtask : pulse

  task automatic bits(input logic [7:0] c, input int first, output logic [15:0] word);
    logic q;
    word = 16'h0000;
    for (int k = first; k < 16; k++) begin
      pulse((k < 8) ? c[7-k] : 1'b0, q);
      word[15-k] = q;
    end
    din = 1'b0;
    sel(1'b1);
  endtask : bits
endmodule : acp_host_model
`default_nettype wire

/* File: verification/adc_power_mode_control_test.sv */
// self-checking bench for the converter power-mode control
`timescale 1ns/1ns
`default_nettype none

module adc_power_mode_control_test;
  logic            ref_clk;
  logic            arst_n;
  logic            res_valid;
  logic            dout_last;
  logic [11:0]     res_data;
  wire logic       cs_n;
  wire logic       sclk;
  wire logic       din;
  wire logic       dout_o;
  wire logic       dout_oe;
  wire logic       dout_line;
  wire logic       res_ready;
  wire logic       ref_enable;
  wire logic       ref_is_supply;
  wire logic       pwr_on;
  wire logic       pwr_waking;
  wire logic       channel_sel;
  wire logic       track;
  wire logic       sample_pulse;
  wire logic       conv_busy;
  wire logic       conv_done;
  wire logic       conv_abort;
  wire logic [7:0] ctrl_word;
  wire logic [1:0] pm_mode;
  int              mismatches;
  int              samples_checked;
  int              n_done;
  int              n_abort;
  int              n_sample;
  logic [11:0]     expq[$];

  acp_adc_power_ctrl dut (
    .ref_clk       (ref_clk),
    .arst_n        (arst_n),
    .cs_n          (cs_n),
    .sclk          (sclk),
    .din           (din),
    .dout_o        (dout_o),
    .dout_oe       (dout_oe),
    .res_data      (res_data),
    .res_valid     (res_valid),
    .res_ready     (res_ready),
    .ctrl_word     (ctrl_word),
    .pm_mode       (pm_mode),
    .channel_sel   (channel_sel),
    .ref_enable    (ref_enable),
    .ref_is_supply (ref_is_supply),
    .pwr_on        (pwr_on),
    .pwr_waking    (pwr_waking),
    .track         (track),
    .sample_pulse  (sample_pulse),
    .conv_busy     (conv_busy),
    .conv_done     (conv_done),
    .conv_abort    (conv_abort)
  );

  acp_host_model host (
    .ref_clk (ref_clk),
    .cs_n    (cs_n),
    .sclk    (sclk),
    .din     (din),
    .dout    (dout_line)
  );

  // released line floats: show the inverse so a stale bit never passes
  assign dout_line = dout_oe ? dout_o : ~dout_last;

  always @(posedge ref_clk) begin
    if (!arst_n) dout_last <= 1'b0;
    else if (dout_oe === 1'b1) dout_last <= dout_o;
    if (conv_done === 1'b1) n_done++;
    if (conv_abort === 1'b1) n_abort++;
    if (sample_pulse === 1'b1) n_sample++;
  end

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test;
    $display("comparisons %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test

  task automatic push(input logic [11:0] v);
    @(negedge ref_clk);
    res_data  = v;
    res_valid = 1'b1;
    for (int i = 0; i < 200; i++) begin
      @(posedge ref_clk);
      if (res_ready === 1'b1) break;
    end
    expq.push_back(v);
    @(negedge ref_clk);
    res_valid = 1'b0;
  endtask : push

  // one frame; an empty buffer yields a zero result
  task automatic conv(input logic [7:0] c, input int lead, input int first);
    int          d0;
    int          s0;
    logic [15:0] w;
    logic [11:0] e;
    d0 = n_done;
    s0 = n_sample;
    e  = (expq.size() > 0) ? expq.pop_front() : 12'h000;
    host.sel(1'b0);
    host.wait_cyc(lead);
    host.bits(c, first, w);
    check(w, {4'h0, e});
    check(16'(n_done - d0), 16'h0001);
    check(16'(n_sample - s0), 16'h0001);
    check(dout_oe, 16'h0000);
    check(ctrl_word, {8'h00, c});
  endtask : conv

  task automatic t_reset;
    check(ctrl_word, 16'h0000);
    check(pm_mode, 16'h0000);
    check(pwr_on, 16'h0000);
    check(dout_oe, 16'h0000);
    check(res_ready, 16'h0001);
  endtask : t_reset

  task automatic t_gated;
    push(12'habc);
    push(12'h5a3);
    host.sel(1'b0);
    check(pwr_waking, 16'h0001);
    host.wait_cyc(55);
    check(pwr_on, 16'h0001);
    check(ref_enable, 16'h0001);
    conv(8'h00, 0, 0);
    check(pwr_on, 16'h0000);
  endtask : t_gated

  task automatic t_abort;
    int   a0;
    int   d0;
    logic q;
    a0 = n_abort;
    d0 = n_done;
    if (expq.size() > 0) void'(expq.pop_front());
    host.sel(1'b0);
    host.wait_cyc(55);
    host.pulse(1'b0, q);
    check(track, 16'h0001);
    check(conv_busy, 16'h0000);
    host.pulse(1'b0, q);
    check(conv_busy, 16'h0001);
    check(track, 16'h0000);
    host.pulse(1'b0, q);
    host.sel(1'b1);
    check(16'(n_abort - a0), 16'h0001);
    check(16'(n_done - d0), 16'h0000);
    check(pwr_on, 16'h0000);
  endtask : t_abort

  task automatic t_always;
    conv(8'h01, 55, 0);
    host.wait_cyc(60);
    check(pwr_on, 16'h0001);
    push(12'h0f0);
    conv(8'h01, 0, 0);
    conv(8'h21, 0, 0);
    check(ref_enable, 16'h0000);
    check(pwr_on, 16'h0001);
    conv(8'h0d, 0, 0);
    check(ref_is_supply, 16'h0001);
    check(ref_enable, 16'h0000);
    check(channel_sel, 16'h0001);
    conv(8'h01, 0, 0);
    check(ref_enable, 16'h0001);
  endtask : t_always

  task automatic t_auto;
    logic q;
    conv(8'h02, 0, 0);
    check(pm_mode, 16'h0002);
    check(pwr_on, 16'h0000);
    check(ref_enable, 16'h0000);
    host.sel(1'b0);
    host.wait_cyc(10);
    check(pwr_waking, 16'h0000);
    host.pulse(1'b0, q);
    host.wait_cyc(2);
    check(pwr_waking, 16'h0001);
    host.wait_cyc(55);
    conv(8'h03, 0, 1);
    check(pwr_on, 16'h0000);
    check(ref_enable, 16'h0001);
    host.sel(1'b0);
    host.pulse(1'b0, q);
    host.wait_cyc(2);
    check(pwr_waking, 16'h0001);
    host.wait_cyc(14);
    check(pwr_on, 16'h0001);
    conv(8'h20, 0, 1);
    host.sel(1'b0);
    host.wait_cyc(13);
    check(pwr_on, 16'h0001);
    conv(8'h00, 0, 0);
    check(pm_mode, 16'h0000);
  endtask : t_auto

  task automatic t_fifo;
    while (expq.size() < 32) push(12'h100 + 12'(expq.size()));
    check(res_ready, 16'h0000);
    // held word must wait for the slot that the next sample frees
    fork
      push(12'hfff);
      begin
        host.wait_cyc(3);
        check(res_ready, 16'h0000);
        conv(8'h01, 55, 0);
      end
    join
    repeat (31) conv(8'h01, 0, 0);
    check(res_ready, 16'h0001);
    conv(8'h01, 0, 0);
  endtask : t_fifo

  // second reset from always-on with power up
  task automatic t_rst;
    @(negedge ref_clk);
    arst_n = 1'b0;
    host.wait_cyc(3);
    check(pwr_on, 16'h0000);
    check(dout_oe, 16'h0000);
    arst_n = 1'b1;
    host.wait_cyc(5);
    check(pm_mode, 16'h0000);
    conv(8'h00, 55, 0);
    check(pwr_on, 16'h0000);
  endtask : t_rst

  initial begin
    arst_n    = 1'b0;
    res_valid = 1'b0;
    res_data  = 12'h000;
    repeat (20) @(negedge ref_clk);
    arst_n = 1'b1;
    repeat (5) @(negedge ref_clk);
    t_reset();
    t_gated();
    t_abort();
    t_always();
    t_auto();
    t_fifo();
    t_rst();
    stop_test();
  end

  // whole run is about 6800 cycles
  initial begin
    #3000000;
    mismatches++;
    stop_test();
  end
endmodule : adc_power_mode_control_test
`default_nettype wire
